/* hw/bnd_bus_bridge.sv */
// Operation
// - 4 GB memory, 64 KB I/O space
// - Memory is quadwords selected by upper address
// - I/O space is 32-bit quantities
// - Boundary-crossing operands split into two cycles
// - Upper lines high address; lane enables low
// - Lane n carries data bits 8n..8n+7
// - Enables mark valid write or expected bytes
// - Asserted lanes always one contiguous run
// - Split operands send highest bytes first
`timescale 1ns/1ps
`default_nettype none
`include "bnd_defines.svh"

module bnd_bus_bridge (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Operand request from the core
    input wire logic req_valid_i,
    input wire bnd_pkg::bnd_req_t req_i,
    output logic req_ready_o,
    // Operand answer to the core
    output logic rsp_valid_o,
    output logic [63:0] rsp_rdata_o,
    output logic rsp_error_o,
    // Processor bus
    output logic bus_active_o,
    output logic bus_write_o,
    output logic bus_io_o,
    output logic [28:0] quadword_address_o,
    output logic [7:0] byte_lane_enable_n_o,
    output logic [63:0] data_lanes_o,
    input wire logic [63:0] data_lanes_i,
    input wire logic burst_ready_n_i,
    // Narrow memory decode
    output bnd_pkg::bnd_dec_t narrow_dec_o
);

    bnd_pkg::bnd_state_t state;
    bnd_pkg::bnd_state_t next_state;

    // Request analysis
    logic [31:0] eff_addr;
    logic [2:0] offset;
    logic [4:0] nbytes;
    logic [4:0] bound_pos;
    logic [4:0] end_pos;
    logic crossing;
    logic upper_qword;
    logic bad_io;
    logic [15:0] mask16;
    logic [127:0] wide_wdata;
    logic [7:0] hi_lanes;
    logic [7:0] lo_lanes;
    logic [28:0] hi_qaddr;
    logic [28:0] qaddr;

    // Captured operand state
    logic split;
    logic hi_in_upper;
    logic [2:0] cap_offset;
    logic [7:0] second_lanes;
    logic [28:0] second_qaddr;
    logic [63:0] second_data;
    logic [127:0] rbuf;
    logic [127:0] next_rbuf;
    logic [127:0] shifted_rbuf;
    logic beat_done;

    // I/O start address wraps within its 64 KB window, memory uses all 32 bits
    assign eff_addr = req_i.io ?
        {{(`BND_ADDR_W - `BND_IO_ADDR_W){1'b0}}, req_i.addr[`BND_IO_ADDR_W - 1:0]} :
        req_i.addr;
    assign offset = eff_addr[2:0];
    assign qaddr = eff_addr[31:3];

    // Operand length in bytes
    always_comb begin
        unique case (req_i.size)
            bnd_pkg::BND_SIZE_1: nbytes = `BND_BYTES_1;
            bnd_pkg::BND_SIZE_2: nbytes = `BND_BYTES_2;
            bnd_pkg::BND_SIZE_4: nbytes = `BND_BYTES_4;
            bnd_pkg::BND_SIZE_8: nbytes = `BND_BYTES_8;
        endcase
    end

    // I/O holds at most dword quantities
    assign bad_io = req_i.io && (req_i.size == bnd_pkg::BND_SIZE_8);

    // Contiguous run of lanes over two quadwords; one shifted run can never gap
    assign mask16 = ((16'h0001 << nbytes) - 16'h0001) << offset;

    // Boundary that the operand must not cross: quadword for 8 bytes, else dword
    always_comb begin
        if (req_i.size == bnd_pkg::BND_SIZE_8) begin
            bound_pos = `BND_QWORD_BYTES;
        end else if (offset < 3'h4) begin
            bound_pos = `BND_DWORD_BYTES;
        end else begin
            bound_pos = `BND_QWORD_BYTES;
        end
    end
    assign end_pos = {2'h0, offset} + nbytes;
    assign crossing = end_pos > bound_pos;
    assign upper_qword = bound_pos == `BND_QWORD_BYTES;

    // High piece lands in the next quadword only past a quadword boundary
    always_comb begin
        if (!crossing) begin
            hi_lanes = mask16[7:0];
            lo_lanes = `BND_LANES_NONE;
            hi_qaddr = qaddr;
        end else if (upper_qword) begin
            hi_lanes = mask16[15:8];
            lo_lanes = mask16[7:0];
            hi_qaddr = qaddr + 29'h1;
        end else begin
            hi_lanes = mask16[7:0] & `BND_LANES_HIGH_DW;
            lo_lanes = mask16[7:0] & `BND_LANES_LOW_DW;
            hi_qaddr = qaddr;
        end
    end

    // Write data moved onto the lanes of its bytes
    assign wide_wdata = {64'h0, req_i.wdata} << {offset, 3'h0};

    // Read beat merged into the buffer, only on the lanes asked for
    always_comb begin
        next_rbuf = rbuf;
        for (int i = 0; i < `BND_LANES; i++) begin
            if (!byte_lane_enable_n_o[i]) begin
                if (state == bnd_pkg::BND_ST_HIGH && hi_in_upper) begin
                    next_rbuf[64 + 8 * i +: 8] = data_lanes_i[8 * i +: 8];
                end else begin
                    next_rbuf[8 * i +: 8] = data_lanes_i[8 * i +: 8];
                end
            end
        end
    end
    assign shifted_rbuf = next_rbuf >> {cap_offset, 3'h0};

    // One ready per cycle returns every requested byte
    assign beat_done = bus_active_o && !burst_ready_n_i;

    // Sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            bnd_pkg::BND_ST_IDLE: begin
                if (req_valid_i) begin
                    next_state = bad_io ? bnd_pkg::BND_ST_RESP : bnd_pkg::BND_ST_HIGH;
                end
            end
            bnd_pkg::BND_ST_HIGH: begin
                if (beat_done) begin
                    next_state = split ? bnd_pkg::BND_ST_LOW : bnd_pkg::BND_ST_RESP;
                end
            end
            bnd_pkg::BND_ST_LOW: begin
                if (beat_done) begin
                    next_state = bnd_pkg::BND_ST_RESP;
                end
            end
            bnd_pkg::BND_ST_RESP: next_state = bnd_pkg::BND_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state <= bnd_pkg::BND_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Bus drive: the highest-order piece goes out first
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            bus_active_o <= 1'b0;
            bus_write_o <= 1'b0;
            bus_io_o <= 1'b0;
            quadword_address_o <= '0;
            byte_lane_enable_n_o <= `BND_LANES_ALL;
            data_lanes_o <= '0;
        end else if (state == bnd_pkg::BND_ST_IDLE && req_valid_i && !bad_io) begin
            bus_active_o <= 1'b1;
            bus_write_o <= req_i.write;
            bus_io_o <= req_i.io;
            quadword_address_o <= hi_qaddr;
            byte_lane_enable_n_o <= ~hi_lanes;
            data_lanes_o <= upper_qword && crossing ? wide_wdata[127:64] :
                wide_wdata[63:0];
        end else if (state == bnd_pkg::BND_ST_HIGH && beat_done && split) begin
            quadword_address_o <= second_qaddr;
            byte_lane_enable_n_o <= ~second_lanes;
            data_lanes_o <= second_data;
        end else if (beat_done) begin
            // Enables released between operands so no lane is left asserted
            bus_active_o <= 1'b0;
            byte_lane_enable_n_o <= `BND_LANES_ALL;
        end
    end

    // Second piece and alignment kept for the rest of the operand
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            split <= 1'b0;
            hi_in_upper <= 1'b0;
            cap_offset <= 3'h0;
            second_lanes <= `BND_LANES_NONE;
            second_qaddr <= '0;
            second_data <= '0;
        end else if (state == bnd_pkg::BND_ST_IDLE && req_valid_i) begin
            split <= crossing;
            hi_in_upper <= crossing && upper_qword;
            cap_offset <= offset;
            second_lanes <= lo_lanes;
            second_qaddr <= qaddr;
            second_data <= wide_wdata[63:0];
        end
    end

    // Read buffer cleared per operand, filled per beat
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rbuf <= '0;
        end else if (state == bnd_pkg::BND_ST_IDLE) begin
            rbuf <= '0;
        end else if (beat_done) begin
            rbuf <= next_rbuf;
        end
    end

    // Answer to the core, realigned to byte zero of the operand
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rsp_rdata_o <= '0;
            rsp_error_o <= 1'b0;
        end else if (state == bnd_pkg::BND_ST_IDLE && req_valid_i) begin
            rsp_rdata_o <= '0;
            rsp_error_o <= bad_io;
        end else if (beat_done && next_state == bnd_pkg::BND_ST_RESP) begin
            rsp_rdata_o <= bus_write_o ? 64'h0 : shifted_rbuf[63:0];
        end
    end

    assign req_ready_o = state == bnd_pkg::BND_ST_IDLE;
    assign rsp_valid_o = state == bnd_pkg::BND_ST_RESP;

    // Decode follows the enables on the bus in the same cycle
    bnd_lane_decoder u_decoder (
        .byte_lane_enable_n_i(byte_lane_enable_n_o),
        .dec_o(narrow_dec_o)
    );

endmodule

`default_nettype wire

/* hw/bnd_defines.svh */
`ifndef BND_DEFINES_SVH
`define BND_DEFINES_SVH

// Bus geometry
`define BND_LANES 8
`define BND_QWORD_BYTES 5'h08
`define BND_DWORD_BYTES 5'h04
`define BND_QADDR_W 29
`define BND_ADDR_W 32
`define BND_IO_ADDR_W 16
`define BND_DATA_W 64

// Operand sizes in bytes
`define BND_BYTES_1 5'h01
`define BND_BYTES_2 5'h02
`define BND_BYTES_4 5'h04
`define BND_BYTES_8 5'h08

// Lane masks for the halves of the quadword, all lanes and no lanes
`define BND_LANES_LOW_DW 8'h0f
`define BND_LANES_HIGH_DW 8'hf0
`define BND_LANES_ALL 8'hff
`define BND_LANES_NONE 8'h00

`endif

/* hw/bnd_lane_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bnd_defines.svh"

module bnd_lane_decoder (
    // Lane enables from the bus
    input wire logic [7:0] byte_lane_enable_n_i,
    // Narrow memory decode
    output bnd_pkg::bnd_dec_t dec_o
);

    logic [2:0] lowest;
    logic [3:0] high_term;
    logic any_lane;

    // Index of the lowest asserted lane; scan downward so the lowest wins
    always_comb begin
        lowest = 3'h0;
        any_lane = 1'b0;
        for (int i = `BND_LANES - 1; i >= 0; i--) begin
            if (!byte_lane_enable_n_i[i]) begin
                lowest = 3'(i);
                any_lane = 1'b1;
            end
        end
    end

    // Odd lane k*2+1 low with every lane below 2k high selects the high half
    genvar k;
    generate
        for (k = 0; k < `BND_LANES / 2; k++) begin : g_half
            localparam logic [7:0] BELOW = 8'((1 << (2 * k)) - 1);
            assign high_term[k] = !byte_lane_enable_n_i[2 * k + 1] &&
                (&(byte_lane_enable_n_i | ~BELOW));
            // Combined lane enables pair lane k with lane k+4
            assign dec_o.combined_lane_enable_n[k] =
                byte_lane_enable_n_i[k] | byte_lane_enable_n_i[k + 4];
        end
    endgenerate

    // Dword and word addressing reuse the low address bits
    assign dec_o.low_address_bits = lowest;
    assign dec_o.low_half_select_n = !(any_lane && !lowest[0]);
    assign dec_o.high_half_select_n = !(|high_term);

endmodule

`default_nettype wire

/* hw/bnd_pkg.sv */
package bnd_pkg;

    // Operand length of a processor access
    typedef enum logic [1:0] {
        BND_SIZE_1 = 2'b00,
        BND_SIZE_2 = 2'b01,
        BND_SIZE_4 = 2'b10,
        BND_SIZE_8 = 2'b11
    } bnd_size_t;

    // Bus sequencer states
    typedef enum logic [1:0] {
        BND_ST_IDLE = 2'b00,
        BND_ST_HIGH = 2'b01,
        BND_ST_LOW = 2'b10,
        BND_ST_RESP = 2'b11
    } bnd_state_t;

    // One operand request from the core
    typedef struct packed {
        logic [31:0] addr;
        bnd_size_t size;
        logic write;
        logic io;
        logic [63:0] wdata;
    } bnd_req_t;

    // Decode for narrow memories
    typedef struct packed {
        logic [2:0] low_address_bits;
        logic low_half_select_n;
        logic high_half_select_n;
        logic [3:0] combined_lane_enable_n;
    } bnd_dec_t;

endpackage

/* verif/bnd_bus_bridge_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module bnd_bus_bridge_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Bus and decode
    input wire logic bus_active_o,
    input wire logic burst_ready_n_i,
    input wire logic [28:0] quadword_address_o,
    input wire logic [7:0] byte_lane_enable_n_o,
    input wire bnd_pkg::bnd_dec_t narrow_dec_o
);
    logic [7:0] act;
    logic [7:0] low_bit;
    logic [2:0] lab;
    // Asserted lanes, lowest of them, decoded index
    assign act = ~byte_lane_enable_n_o;
    assign low_bit = act & (~act + 8'h01);
    assign lab = narrow_dec_o.low_address_bits;
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    chk_lane_run: assert property (((act + low_bit) & act) == 8'h00)
        else $error("lanes not one run");
    chk_low_bits: assert property (act != 8'h00 |-> low_bit == (8'h01 << lab))
        else $error("low bits wrong");
    chk_low_half: assert property (act != 8'h00 |->
        narrow_dec_o.low_half_select_n == lab[0])
        else $error("low half wrong");
    chk_high_half: assert property (act != 8'h00 |->
        narrow_dec_o.high_half_select_n == !act[{lab[2:1], 1'b1}])
        else $error("high half wrong");
    // One check for all four combined enables keeps the file short
    chk_comb_lanes: assert property (
        narrow_dec_o.combined_lane_enable_n ==
        (byte_lane_enable_n_o[3:0] | byte_lane_enable_n_o[7:4]))
        else $error("combined enable wrong");
    chk_idle_lanes: assert property (!bus_active_o |-> act == 8'h00)
        else $error("lanes asserted while idle");
    chk_hold_bus: assert property (bus_active_o && burst_ready_n_i |=> bus_active_o &&
        $stable(quadword_address_o) && $stable(byte_lane_enable_n_o))
        else $error("bus changed before beat");
    chk_split_high: assert property (
        bus_active_o && !burst_ready_n_i ##1 bus_active_o |->
        quadword_address_o + 29'h1 == $past(quadword_address_o) ||
        act < ~$past(byte_lane_enable_n_o))
        else $error("split order wrong");
endmodule
bind bnd_bus_bridge bnd_bus_bridge_asserts bnd_bus_bridge_asserts_inst (.clk_i, .reset_n_i,
    .bus_active_o, .burst_ready_n_i, .quadword_address_o, .byte_lane_enable_n_o, .narrow_dec_o);
`default_nettype wire

/* verif/bnd_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bnd_mem_model (
    // Clock and pacing
    input wire logic clk_i,
    input wire logic slow_i,
    // Bus from the bridge
    input wire logic active_i,
    input wire logic write_i,
    input wire logic [28:0] qaddr_i,
    input wire logic [7:0] lane_n_i,
    input wire logic [63:0] wdata_i,
    // Answer to the bridge
    output logic ready_n_o,
    output logic [63:0] rdata_o
);
    logic [63:0] mem [16] = '{default: 64'h0};
    logic [1:0] waits = 2'h0;
    // Slow mode inserts two wait cycles before each beat
    always_ff @(posedge clk_i) begin
        if (active_i && ready_n_o) begin
            waits <= waits + 2'h1;
        end else begin
            waits <= 2'h0;
        end
    end
    assign ready_n_o = !(active_i && (!slow_i || waits == 2'h2));
    // Unrequested lanes carry inverted bytes so a stray lane is seen
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            rdata_o[8*n +: 8] = mem[qaddr_i[3:0]][8*n +: 8] ^
                {8{lane_n_i[n] | !active_i}};
        end
    end
    // Only enabled lanes are written, at the beat
    always_ff @(posedge clk_i) begin
        for (int n = 0; n < 8; n++) begin
            if (active_i && !ready_n_o && write_i && !lane_n_i[n]) begin
                mem[qaddr_i[3:0]][8*n +: 8] <= wdata_i[8*n +: 8];
            end
        end
    end
endmodule
`default_nettype wire

/* verif/tb_byte_enable_narrow_memory_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_byte_enable_narrow_memory_decoder;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    bnd_pkg::bnd_req_t req_i = '0;
    logic slow = 1'b0;
    logic req_ready_o, rsp_valid_o, rsp_error_o, bus_active_o, bus_write_o, bus_io_o;
    logic burst_ready_n_i;
    logic [63:0] rsp_rdata_o, data_lanes_o, data_lanes_i;
    logic [28:0] quadword_address_o;
    logic [7:0] byte_lane_enable_n_o;
    bnd_pkg::bnd_dec_t narrow_dec_o;
    bnd_pkg::bnd_dec_t exp_dec;
    logic cur_io = 1'b0;
    logic [64:0] expq [$];
    logic [7:0] shadow [128] = '{default: 8'h00};
    int miscompares = 0;
    int n_checks = 0;
    int seed = 32'h93499d3c;
    always #50 clk_i = ~clk_i;
    bnd_bus_bridge bnd_bus_bridge_inst (.clk_i, .reset_n_i, .req_valid_i, .req_i, .req_ready_o,
        .rsp_valid_o, .rsp_rdata_o, .rsp_error_o, .bus_active_o, .bus_write_o, .bus_io_o,
        .quadword_address_o, .byte_lane_enable_n_o, .data_lanes_o, .data_lanes_i,
        .burst_ready_n_i, .narrow_dec_o);
    bnd_mem_model bnd_mem_model_inst (.clk_i, .slow_i(slow), .active_i(bus_active_o),
        .write_i(bus_write_o), .qaddr_i(quadword_address_o), .lane_n_i(byte_lane_enable_n_o),
        .wdata_i(data_lanes_o), .ready_n_o(burst_ready_n_i), .rdata_o(data_lanes_i));
    task automatic check(input logic [64:0] seen, input logic [64:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Reference decode: lowest asserted lane picks the address bits and both half selects
    function automatic bnd_pkg::bnd_dec_t dec_ref(input logic [7:0] e);
        bnd_pkg::bnd_dec_t d;
        logic [2:0] lo;
        lo = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (!e[i]) begin
                lo = 3'(i);
            end
        end
        d.low_address_bits = lo;
        d.low_half_select_n = !(e != 8'hff && !lo[0]);
        d.high_half_select_n = !(e != 8'hff && !e[{lo[2:1], 1'b1}]);
        d.combined_lane_enable_n = e[3:0] | e[7:4];
        return d;
    endfunction
    // Note the expected answer, then offer the request until taken
    task automatic op(input logic [31:0] a, input logic [1:0] sz, input logic wr,
                      input logic io, input logic [63:0] wd);
        logic [64:0] exp;
        int k;
        exp = '0;
        if (io && sz == 2'h3) begin
            exp[64] = 1'b1;
        end else begin
            for (int i = 0; i < (1 << sz); i++) begin
                if (wr) begin
                    shadow[7'(a + i)] = wd[8*i +: 8];
                end else begin
                    exp[8*i +: 8] = shadow[7'(a + i)];
                end
            end
        end
        expq.push_back(exp);
        req_i = '{addr: a, size: bnd_pkg::bnd_size_t'(sz), write: wr, io: io, wdata: wd};
        req_valid_i = 1'b1;
        k = 0;
        // Ready is looked at off the edge, where it has settled
        while (req_ready_o !== 1'b1 && k < 30) begin
            @(negedge clk_i);
            k++;
        end
        if (k >= 30) begin
            miscompares++;
            summarize();
        end
        // Bus is idle here, so the watcher cannot see a stale flag
        cur_io = io;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        @(negedge clk_i);
    endtask
    // Watcher: decode every cycle, answers in order of issue
    always @(negedge clk_i) begin
        if (reset_n_i) begin
            exp_dec = dec_ref(byte_lane_enable_n_o);
            check(65'(narrow_dec_o), 65'(exp_dec));
            check(65'(narrow_dec_o[3:0]), 65'(exp_dec[3:0]));
            // I/O cycles must say so on the bus for the whole cycle
            if (bus_active_o === 1'b1) begin
                check(65'(bus_io_o), 65'(cur_io));
            end
            if (rsp_valid_o === 1'b1) begin
                if (expq.size() == 0) begin
                    check(65'h1, 65'h0);
                end else begin
                    check({rsp_error_o, rsp_rdata_o}, expq.pop_front());
                end
            end
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        reset_n_i = 1'b1;
        // Every size and offset at the top of memory, wrapping to zero
        for (int s = 0; s < 4; s++) begin
            for (int o = 0; o < 8; o++) begin
                slow = o[0];
                op(32'hfffffff8 + o, s[1:0], 1'b1, 1'b0, {$random(seed), $random(seed)});
                op(32'hfffffff8 + o, s[1:0], 1'b0, 1'b0, 64'h0);
            end
        end
        $display("test sizes done");
        // I/O beyond the 16-bit space, size 4 straddling a dword; size 8 refused
        for (int s = 0; s < 4; s++) begin
            op(32'h0001fffd, s[1:0], 1'b1, 1'b1, {$random(seed), $random(seed)});
            op(32'h0001fffd, s[1:0], 1'b0, 1'b1, 64'h0);
        end
        $display("test io done");
        repeat (300) begin
            slow = 1'($random(seed));
            op($random(seed), 2'($random(seed)), 1'($random(seed)), 1'($random(seed)),
               {$random(seed), $random(seed)});
        end
        $display("test random done");
        repeat (10) @(negedge clk_i);
        check(65'(expq.size()), 65'h0);
        summarize();
    end
endmodule
`default_nettype wire
